// ---- logic/ebr_ram.sv ----
/*
 Configurable embedded memory block: single-port, simple and true dual-port,
 read-only and first-in first-out use, four clocking schemes, optional output
 registers and pseudo-asynchronous reads.
 Assumes one clock; each port clock is a clock enable, clears are synchronous.
 Data width must be a multiple of the lane width.
*/
`timescale 1ns/1ns
module ebr_ram #(
   parameter ebr_pkg::ebr_mode_t MEM_MODE = ebr_pkg::ebr_true_dp,
   parameter ebr_pkg::ebr_clk_t CLK_SCHEME = ebr_pkg::ebr_indep,
   parameter ebr_pkg::ebr_rdw_t MIXED_RDW = ebr_pkg::ebr_old_data,
   parameter logic [1:0] OUT_REG = 2'h3,
   parameter logic PSEUDO_ASYNC = 1'h0,
   parameter logic TWO_SINGLE = 1'h0,
   parameter int DW = ebr_pkg::DATA_W,
   parameter int AW = ebr_pkg::ADDR_W,
   parameter logic [(2**AW)*DW-1:0] INIT_IMAGE = '0
)(
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic [AW-1:0] addr_a_in,
   input wire logic [DW-1:0] wdata_a_in,
   input wire logic [DW/ebr_pkg::LANE_W-1:0] byteen_a_in,
   input wire logic wren_a_in,
   input wire logic rden_a_in,
   input wire logic clken_a_in,
   input wire logic oclken_a_in,
   input wire logic clr_a_in,
   input wire logic oclr_a_in,
   output logic [DW-1:0] rdata_a_out,
   input wire logic [AW-1:0] addr_b_in,
   input wire logic [DW-1:0] wdata_b_in,
   input wire logic [DW/ebr_pkg::LANE_W-1:0] byteen_b_in,
   input wire logic wren_b_in,
   input wire logic rden_b_in,
   input wire logic clken_b_in,
   input wire logic oclken_b_in,
   input wire logic clr_b_in,
   input wire logic oclr_b_in,
   output logic [DW-1:0] rdata_b_out,
   output logic fifo_full_out,
   output logic fifo_empty_out,
   output logic cfg_ok_out
);
   //****************************************
   // Configuration
   //****************************************
   localparam int BW = DW / ebr_pkg::LANE_W;
   localparam int DEPTH = 2**AW;
   localparam int LW = ebr_pkg::LANE_W;
   localparam logic LEGAL = ebr_pkg::clk_legal(MEM_MODE, CLK_SCHEME);
   localparam ebr_pkg::ebr_clk_t SCH = LEGAL ? CLK_SCHEME : ebr_pkg::clk_default(MEM_MODE);
   localparam logic IS_FIFO = (MEM_MODE == ebr_pkg::ebr_fifo);
   localparam logic IS_SDP = (MEM_MODE == ebr_pkg::ebr_simple_dp) || IS_FIFO;
   localparam logic IS_TDP = (MEM_MODE == ebr_pkg::ebr_true_dp);
   localparam logic IS_ROM = (MEM_MODE == ebr_pkg::ebr_rom);
   // Second single-port memory in the upper half
   localparam logic SPLIT = (MEM_MODE == ebr_pkg::ebr_single) && TWO_SINGLE;
   localparam logic [1:0] WR_OK = {IS_TDP || SPLIT, !IS_ROM};
   localparam logic [1:0] RD_OK = {(MEM_MODE != ebr_pkg::ebr_single) || SPLIT, !IS_SDP};
   // Falling-edge read address only in dual-port modes
   localparam logic PSEUDO = PSEUDO_ASYNC && (IS_TDP || (MEM_MODE == ebr_pkg::ebr_simple_dp));
   // Old word if MIXED_RDW chooses it, unless the two ports use independent clocks
   localparam logic MIX_OLD = (MIXED_RDW == ebr_pkg::ebr_old_data) && (SCH != ebr_pkg::ebr_indep);
   localparam logic [1:0] OREG = IS_FIFO ? 2'h0 : OUT_REG;

   logic [DW-1:0] mem [DEPTH];
   logic [AW-1:0] addr_i [2];
   logic [AW-1:0] wa_q [2];
   logic [AW-1:0] ra_q [2];
   logic [DW-1:0] wd_i [2];
   logic [DW-1:0] wd_q [2];
   logic [DW-1:0] old_q [2];
   logic [DW-1:0] out_q [2];
   logic [DW-1:0] raw [2];
   logic [DW-1:0] rd_o [2];
   logic [BW-1:0] be_i [2];
   logic [BW-1:0] be_q [2];
   logic we_i [2];
   logic re_i [2];
   logic in_en [2];
   logic in_clr [2];
   logic out_en [2];
   logic out_clr [2];
   logic we_q [2];
   logic re_q [2];
   logic hit [2];
   logic [AW:0] wptr;
   logic [AW:0] rptr;
   logic push;
   logic pop;
   logic fifo_full;
   logic fifo_empty;

   function automatic logic [AW-1:0] map_addr(input logic [AW-1:0] a, input logic hi);
      map_addr = SPLIT ? {hi, a[AW-2:0]} : a;
   endfunction

   //****************************************
   // Port and clock-scheme mapping
   //****************************************
   assign addr_i[0] = addr_a_in;
   assign addr_i[1] = addr_b_in;
   assign wd_i[0] = wdata_a_in;
   assign wd_i[1] = wdata_b_in;
   assign be_i[0] = byteen_a_in;
   assign be_i[1] = byteen_b_in;
   assign we_i[0] = wren_a_in;
   assign we_i[1] = wren_b_in;
   assign re_i[0] = rden_a_in;
   assign re_i[1] = rden_b_in;
   // Port clock drives inputs; output group follows it except in input/output
   assign in_en[0] = clken_a_in;
   assign in_en[1] = clken_b_in;
   assign in_clr[0] = clr_a_in;
   assign in_clr[1] = clr_b_in;
   assign out_en[0] = (SCH == ebr_pkg::ebr_in_out) ? oclken_a_in : clken_a_in;
   assign out_en[1] = (SCH == ebr_pkg::ebr_in_out) ? oclken_b_in : clken_b_in;
   assign out_clr[0] = (SCH == ebr_pkg::ebr_in_out) ? oclr_a_in : clr_a_in;
   assign out_clr[1] = (SCH == ebr_pkg::ebr_in_out) ? oclr_b_in : clr_b_in;

   //****************************************
   // FIFO pointers
   //****************************************
   assign fifo_full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
   assign fifo_empty = (wptr == rptr);
   assign push = IS_FIFO && in_en[0] && we_i[0] && !fifo_full;
   assign pop = IS_FIFO && in_en[1] && re_i[1] && !fifo_empty;

   always_ff @(posedge mclk_in)
   begin
      if (!resetn_in || in_clr[0])
         wptr <= '0;
      else if (push)
         wptr <= wptr + 1'h1;
   end

   always_ff @(posedge mclk_in)
   begin
      if (!resetn_in || in_clr[1])
         rptr <= '0;
      else if (pop)
         rptr <= rptr + 1'h1;
   end

   //****************************************
   // Storage array, falling-edge commit
   //****************************************
   always_ff @(negedge mclk_in)
   begin
      if (!resetn_in)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem[i] <= INIT_IMAGE[i*DW +: DW];
      end
      else
      begin
         for (int p = 0; p < 2; p++)
            for (int l = 0; l < BW; l++)
               if (we_q[p] && be_q[p][l])
                  mem[wa_q[p]][l*LW +: LW] <= wd_q[p][l*LW +: LW];
      end
   end

   //****************************************
   // Per-port registers and read path
   //****************************************
   genvar p;
   generate
      for (p = 0; p < 2; p++)
      begin : g_port
         localparam int O = 1 - p;

         // Input registers; strobe lives one enabled cycle only
         always_ff @(posedge mclk_in)
         begin
            if (!resetn_in || in_clr[p])
            begin
               wa_q[p] <= '0;
               wd_q[p] <= '0;
               be_q[p] <= '0;
               we_q[p] <= ebr_pkg::RST_BIT;
            end
            else if (IS_FIFO && (p == 0))
            begin
               we_q[p] <= push;
               if (push)
               begin
                  wa_q[p] <= wptr[AW-1:0];
                  wd_q[p] <= wd_i[p];
                  be_q[p] <= '1;
               end
            end
            else if (in_en[p])
            begin
               wa_q[p] <= map_addr(addr_i[p], (p == 1));
               wd_q[p] <= wd_i[p];
               be_q[p] <= be_i[p];
               we_q[p] <= we_i[p] && WR_OK[p];
            end
            else
               we_q[p] <= ebr_pkg::RST_BIT;
         end

         // Read address and enable, rising or falling edge
         if (PSEUDO)
         begin : g_neg
            always_ff @(negedge mclk_in)
            begin
               if (!resetn_in || in_clr[p])
               begin
                  ra_q[p] <= '0;
                  re_q[p] <= ebr_pkg::RST_BIT;
               end
               else if (in_en[p])
               begin
                  re_q[p] <= re_i[p] && RD_OK[p];
                  if (re_i[p] || we_i[p])
                     ra_q[p] <= map_addr(addr_i[p], (p == 1));
               end
            end
         end
         else
         begin : g_pos
            always_ff @(posedge mclk_in)
            begin
               if (!resetn_in || in_clr[p])
               begin
                  ra_q[p] <= '0;
                  re_q[p] <= ebr_pkg::RST_BIT;
               end
               else if (in_en[p])
               begin
                  re_q[p] <= re_i[p] && RD_OK[p];
                  if (re_i[p] || we_i[p])
                     ra_q[p] <= map_addr(addr_i[p], (p == 1));
               end
            end
         end

         // Word before this falling-edge write, for old-data reads
         always_ff @(negedge mclk_in)
         begin
            if (!resetn_in)
               old_q[p] <= '0;
            else
               old_q[p] <= mem[ra_q[p]];
         end

         // Mixed-port hit: other port writes the address read here
         assign hit[p] = MIX_OLD && we_q[O] && (wa_q[O] == ra_q[p]);
         // Same-port hit reads the array, already holding the new word
         assign raw[p] = hit[p] ? old_q[p] : mem[ra_q[p]];

         // Output register, held while read enable is low
         always_ff @(posedge mclk_in)
         begin
            if (!resetn_in || out_clr[p])
               out_q[p] <= '0;
            else if (out_en[p] && re_q[p])
               out_q[p] <= raw[p];
         end

         if (IS_FIFO && (p == 1))
         begin : g_fifo_out
            assign rd_o[p] = mem[rptr[AW-1:0]];
         end
         else
         begin : g_ram_out
            assign rd_o[p] = OREG[p] ? out_q[p] : raw[p];
         end
      end
   endgenerate

   assign rdata_a_out = rd_o[0];
   assign rdata_b_out = rd_o[1];
   assign fifo_full_out = fifo_full;
   assign fifo_empty_out = fifo_empty;
   assign cfg_ok_out = LEGAL;

   //****************************************
   // Assertions
   //****************************************
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!resetn_in);

   AST_ROM_NO_WRITE: assert property (IS_ROM |-> !we_q[0] && !we_q[1])
      else $error("write strobe in read-only mode");
   AST_IN_CAPTURE: assert property (!IS_FIFO && !SPLIT && in_en[0] && !in_clr[0]
      |=> wa_q[0] == $past(addr_i[0]))
      else $error("port A address not registered");
   AST_STROBE_ONCE: assert property (!IS_FIFO && !in_en[0] |=> !we_q[0])
      else $error("write strobe without enabled cycle");
   AST_GATED_HOLD: assert property (!IS_FIFO && !in_en[0] && !in_clr[0] |=> $stable(wa_q[0]))
      else $error("gated port A input register moved");
   AST_IN_CLEAR: assert property (in_clr[1] |=> !we_q[1] && (wa_q[1] == '0) && !re_q[1])
      else $error("port B clear not taken");
   AST_OUT_CLEAR: assert property (OREG[1] && out_clr[1] |=> rdata_b_out == '0)
      else $error("port B output clear not taken");
   AST_OUT_HOLD: assert property (OREG[1] && !out_en[1] && !out_clr[1] |=> $stable(rdata_b_out))
      else $error("gated port B output moved");
   AST_REG_LATENCY: assert property (OREG[1] && out_en[1] && re_q[1] && !out_clr[1]
      |=> rdata_b_out == $past(raw[1]))
      else $error("port B output register latency wrong");
   AST_FIFO_COMB: assert property (IS_FIFO |-> rdata_b_out == mem[rptr[AW-1:0]])
      else $error("fifo output not from array");
   AST_FIFO_EMPTY_POP: assert property (IS_FIFO && fifo_empty && !in_clr[1] |=> $stable(rptr))
      else $error("pop taken from empty fifo");
   AST_SAME_PORT_RDW: assert property (!OREG[0] && we_q[0] && (be_q[0] == '1) && (ra_q[0] == wa_q[0])
      && !(we_q[1] && (wa_q[1] == wa_q[0])) |-> rdata_a_out == wd_q[0])
      else $error("same-port read misses new data");
   AST_MIXED_OLD: assert property (MIX_OLD && we_q[0] && (ra_q[1] == wa_q[0]) |-> raw[1] == old_q[1])
      else $error("mixed-port read not old data");

   COV_FIFO_FULL: cover property (IS_FIFO && fifo_full ##1 pop);
   COV_SAME_RDW: cover property (we_q[0] && (ra_q[0] == wa_q[0]));
   COV_MIXED_RDW: cover property (hit[1]);
   COV_OUT_CLEAR: cover property (out_clr[0] ##1 re_q[0]);
endmodule

// ---- shared/ebr_pkg.sv ----
/*
 Shared types and constants of the embedded memory block: memory modes,
 clocking schemes, mixed-port read-during-write choice, default geometry.
 Assumes nothing of its surroundings.
*/
package ebr_pkg;
   typedef enum {ebr_single, ebr_simple_dp, ebr_true_dp, ebr_rom, ebr_fifo} ebr_mode_t;
   typedef enum {ebr_indep, ebr_in_out, ebr_rd_wr, ebr_single_clk} ebr_clk_t;
   typedef enum {ebr_old_data, ebr_undefined_output_choice} ebr_rdw_t;

   localparam int DATA_W = 16;
   localparam int ADDR_W = 8;
   localparam int LANE_W = 8;
   localparam logic RST_BIT = 1'h0;

   // Clocking schemes each memory mode accepts
   function automatic logic clk_legal(input ebr_mode_t m, input ebr_clk_t c);
      case (m)
         ebr_true_dp: clk_legal = (c == ebr_indep) || (c == ebr_in_out);
         ebr_simple_dp, ebr_fifo: clk_legal = (c == ebr_in_out) || (c == ebr_rd_wr);
         default: clk_legal = (c == ebr_single_clk);
      endcase
   endfunction

   // Fallback scheme when an illegal one is requested
   function automatic ebr_clk_t clk_default(input ebr_mode_t m);
      case (m)
         ebr_true_dp: clk_default = ebr_indep;
         ebr_simple_dp, ebr_fifo: clk_default = ebr_in_out;
         default: clk_default = ebr_single_clk;
      endcase
   endfunction
endpackage

// ---- verification/ebr_user_model.sv ----
/*
 Model of the fabric logic that drives both memory ports.
 Assumes the caller invokes its tasks just after a rising clock edge.
*/
`timescale 1ns/1ns
module ebr_user_model #(
   parameter logic FIFO_USE = 1'h0
)(
   input wire logic fifo_empty_in,
   output logic [ebr_pkg::ADDR_W-1:0] addr_a_out,
   output logic [ebr_pkg::DATA_W-1:0] wdata_a_out,
   output logic [1:0] byteen_a_out,
   output logic wren_a_out,
   output logic rden_a_out,
   output logic clken_a_out,
   output logic oclken_a_out,
   output logic clr_a_out,
   output logic oclr_a_out,
   output logic [ebr_pkg::ADDR_W-1:0] addr_b_out,
   output logic [ebr_pkg::DATA_W-1:0] wdata_b_out,
   output logic [1:0] byteen_b_out,
   output logic wren_b_out,
   output logic rden_b_out,
   output logic clken_b_out,
   output logic oclken_b_out,
   output logic clr_b_out,
   output logic oclr_b_out
);
   initial
   begin
      {addr_a_out, wdata_a_out, byteen_a_out, wren_a_out, rden_a_out, clr_a_out, oclr_a_out} = '0;
      {addr_b_out, wdata_b_out, byteen_b_out, wren_b_out, rden_b_out, clr_b_out, oclr_b_out} = '0;
      {clken_a_out, oclken_a_out, clken_b_out, oclken_b_out} = 4'hf;
   end

   // Drops the port B read while the buffer is empty and wren_a_out is already high
   task automatic set(input logic p, input logic we, input logic re, input logic ce,
      input logic [ebr_pkg::ADDR_W-1:0] a, input logic [ebr_pkg::DATA_W-1:0] d, input logic [1:0] be);
      logic re_l;
      re_l = (FIFO_USE && p && fifo_empty_in && wren_a_out) ? 1'b0 : re;
      if (p)
      begin
         {wren_b_out, rden_b_out, clken_b_out} <= {we, re_l, ce};
         {addr_b_out, wdata_b_out, byteen_b_out} <= {a, d, be};
      end
      else
      begin
         {wren_a_out, rden_a_out, clken_a_out} <= {we, re_l, ce};
         {addr_a_out, wdata_a_out, byteen_a_out} <= {a, d, be};
      end
   endtask

   // Released strobes go low; address and data show the inverse of their last value
   task automatic idle(input logic p);
      if (p)
         {wren_b_out, rden_b_out, clken_b_out, addr_b_out, wdata_b_out} <= {2'h0, 1'h1, ~addr_b_out, ~wdata_b_out};
      else
         {wren_a_out, rden_a_out, clken_a_out, addr_a_out, wdata_a_out} <= {2'h0, 1'h1, ~addr_a_out, ~wdata_a_out};
   endtask

   task automatic clear(input logic p, input logic v);
      if (p)
         clr_b_out <= v;
      else
         clr_a_out <= v;
   endtask
endmodule

// ---- verification/embedded_ram_clocking_tb_top.sv ----
/*
 Self-checking bench: true dual-port, independent clocking, port A bypassed,
 port B registered. Assumes the user model drives every memory port input.
*/
`timescale 1ns/1ns
module embedded_ram_clocking_tb_top;
   localparam int AW = ebr_pkg::ADDR_W;
   localparam int DW = ebr_pkg::DATA_W;
   function automatic logic [(2**AW)*DW-1:0] mk_img();
      logic [(2**AW)*DW-1:0] img;
      for (int i = 0; i < 2**AW; i++)
         img[i*DW +: DW] = 16'ha500 ^ DW'(i);
      return img;
   endfunction
   localparam logic [(2**AW)*DW-1:0] IMG = mk_img();
   // ****************
   // Signals
   // ****************
   logic mclk;
   logic resetn;
   logic [AW-1:0] addr_a, addr_b;
   logic [DW-1:0] wdata_a, wdata_b, rdata_a, rdata_b;
   logic [1:0] be_a, be_b;
   logic wren_a, rden_a, clken_a, oclken_a, clr_a, oclr_a;
   logic wren_b, rden_b, clken_b, oclken_b, clr_b, oclr_b;
   logic full, empty, cfg_ok;
   logic [DW-1:0] shadow [2**AW];
   int err_count = 0;
   int checks = 0;

   ebr_ram #(.OUT_REG(2'h2), .INIT_IMAGE(IMG)) u_dut (.mclk_in(mclk), .resetn_in(resetn),
      .addr_a_in(addr_a), .wdata_a_in(wdata_a), .byteen_a_in(be_a), .wren_a_in(wren_a),
      .rden_a_in(rden_a), .clken_a_in(clken_a), .oclken_a_in(oclken_a), .clr_a_in(clr_a),
      .oclr_a_in(oclr_a), .rdata_a_out(rdata_a), .addr_b_in(addr_b), .wdata_b_in(wdata_b),
      .byteen_b_in(be_b), .wren_b_in(wren_b), .rden_b_in(rden_b), .clken_b_in(clken_b),
      .oclken_b_in(oclken_b), .clr_b_in(clr_b), .oclr_b_in(oclr_b), .rdata_b_out(rdata_b),
      .fifo_full_out(full), .fifo_empty_out(empty), .cfg_ok_out(cfg_ok));

   ebr_user_model u_user (.fifo_empty_in(empty), .addr_a_out(addr_a), .wdata_a_out(wdata_a),
      .byteen_a_out(be_a), .wren_a_out(wren_a), .rden_a_out(rden_a), .clken_a_out(clken_a),
      .oclken_a_out(oclken_a), .clr_a_out(clr_a), .oclr_a_out(oclr_a), .addr_b_out(addr_b),
      .wdata_b_out(wdata_b), .byteen_b_out(be_b), .wren_b_out(wren_b), .rden_b_out(rden_b),
      .clken_b_out(clken_b), .oclken_b_out(oclken_b), .clr_b_out(clr_b), .oclr_b_out(oclr_b));

   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // ****************
   // Tasks
   // ****************
   task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic p, input logic [AW-1:0] a, input logic [DW-1:0] d, input logic [1:0] be);
      @(posedge mclk);
      u_user.set(p, 1'b1, 1'b0, 1'b1, a, d, be);
      @(posedge mclk);
      u_user.idle(p);
      for (int k = 0; k < 2; k++)
         if (be[k]) shadow[a][k*8 +: 8] = d[k*8 +: 8];
   endtask

   // Bypassed port A: word settles after the falling edge
   task automatic samp_a(input logic [AW-1:0] a);
      @(negedge mclk);
      #1;
      check(rdata_a, shadow[a]);
   endtask

   task automatic rd(input logic p, input logic [AW-1:0] a);
      @(posedge mclk);
      u_user.set(p, 1'b0, 1'b1, 1'b1, a, '0, 2'h0);
      @(posedge mclk);
      u_user.idle(p);
      if (p)
      begin
         @(posedge mclk);
         #1;
         check(rdata_b, shadow[a]);
      end
      else
         samp_a(a);
   endtask

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ****************
   // Tests
   // ****************
   initial
   begin
      resetn = 1'b0;
      for (int i = 0; i < 2**AW; i++)
         shadow[i] = IMG[i*DW +: DW];
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      check(DW'(cfg_ok), DW'(1'b1));
      check(DW'(empty), DW'(1'b1));
      check(DW'(full), DW'(1'b0));
      for (int i = 0; i < 4; i++)
         rd(1'b1, AW'(i * 85));
      rd(1'b0, 8'hff);
      wr(1'b0, 8'h05, 16'h1234, 2'h3);
      samp_a(8'h05);
      wr(1'b0, 8'h06, 16'h3c3c, 2'h1);
      rd(1'b1, 8'h06);
      wr(1'b1, 8'h07, 16'hbeef, 2'h2);
      rd(1'b0, 8'h07);
      @(posedge mclk);
      u_user.set(1'b0, 1'b1, 1'b0, 1'b0, 8'h08, 16'hdead, 2'h3);
      @(posedge mclk);
      u_user.idle(1'b0);
      rd(1'b1, 8'h08);
      rd(1'b1, 8'h07);
      @(posedge mclk);
      u_user.clear(1'b1, 1'b1);
      @(posedge mclk);
      u_user.clear(1'b1, 1'b0);
      #1;
      check(rdata_b, '0);
      @(posedge mclk);
      for (int i = 0; i < 4; i++)
      begin
         u_user.set(1'b0, 1'b1, 1'b0, 1'b1, AW'(16 + i), 16'h0f00 + DW'(i), 2'h3);
         shadow[16 + i] = 16'h0f00 + DW'(i);
         @(posedge mclk);
      end
      u_user.idle(1'b0);
      for (int i = 0; i < 4; i++)
         rd(1'b1, AW'(16 + i));
      @(posedge mclk);
      u_user.set(1'b0, 1'b1, 1'b0, 1'b1, 8'h09, 16'h5a5a, 2'h3);
      u_user.set(1'b1, 1'b0, 1'b1, 1'b1, 8'h09, '0, 2'h0);
      @(posedge mclk);
      u_user.idle(1'b0);
      u_user.idle(1'b1);
      // Port B word of that collision is left unchecked under separate clocks
      shadow[9] = 16'h5a5a;
      rd(1'b1, 8'h09);
      finish_test();
   end

   initial
   begin
      #(40 * 5000);
      err_count++;
      finish_test();
   end
endmodule
